// File: pkg/lhrts_map.svh
// register offsets, field positions, reset values and scaling of the supervisor
`ifndef LHRTS_MAP_SVH
`define LHRTS_MAP_SVH
`define LHRTS_AW        8
`define LHRTS_ADR_CTRL  8'h00
`define LHRTS_ADR_HOOK  8'h04
`define LHRTS_ADR_RING  8'h08
`define LHRTS_ADR_STAT  8'h0C
`define LHRTS_ADR_INT   8'h10
`define LHRTS_ADR_MASK  8'h14
`define LHRTS_ADR_RDBK  8'h18
`define LHRTS_ADR_LPI   8'h1C
`define LHRTS_CTRL_RING 0
`define LHRTS_CTRL_LPI  1
`define LHRTS_CTRL_METH 2
`define LHRTS_CTRL_TWO  3
`define LHRTS_CTRL_FEED 5:4
`define LHRTS_CTRL_TSEL 7:6
`define LHRTS_CTRL_TEST 8
`define LHRTS_HOOK_THR  15:0
`define LHRTS_HOOK_DEB  31:16
`define LHRTS_RING_RING_TRIP_THRESHOLD 6:0
`define LHRTS_RING_ILR  13:8
`define LHRTS_LPI_THR   15:0
`define LHRTS_CTRL_RST  32'h0000_0008
`define LHRTS_HOOK_RST  32'h0010_0014
`define LHRTS_RING_RST  32'h0000_0A28
`define LHRTS_LPI_RST   32'h0000_0008
`define LHRTS_INT_W     3
`define LHRTS_INT_OFF   0
`define LHRTS_INT_TRIP  1
`define LHRTS_INT_ON    2
`define LHRTS_METH_AC   1'b1
`define LHRTS_CUR_LSB_UA 500
`define LHRTS_ILR_MIN_MA 18
`define LHRTS_ILR_STEP_MA 2
`define LHRTS_ILR_MAX_MA 112
`define LHRTS_FEED_R1   8'h32
`define LHRTS_FEED_R2   8'h64
`define LHRTS_FEED_R3   8'hC8
`define LHRTS_DROP_SHIFT 11
`define LHRTS_TSEL_SREG 2'h0
`define LHRTS_TSEL_DC   2'h1
`define LHRTS_TSEL_AC   2'h2
`endif

// File: pkg/lhrts_pkg.sv
// state types and shared arithmetic of the supervisor
`include "lhrts_map.svh"
package lhrts_pkg;
  typedef struct packed {
    logic        state;
    logic [15:0] cnt;
    logic        rise;
    logic        fall;
  } lhrts_deb_type;

  typedef struct packed {
    logic        prev_ring;
    logic        blank;
    logic        tripped;
    logic [31:0] sum;
    logic [15:0] nsmp;
    logic [15:0] nlim;
    logic [1:0]  cons;
    logic        trip;
  } lhrts_rt_type;

  typedef struct packed {
    logic [31:0]             ctrl;
    logic [31:0]             hook;
    logic [31:0]             ring;
    logic [31:0]             lpi;
    logic [`LHRTS_INT_W-1:0] int_st;
    logic [`LHRTS_INT_W-1:0] mask;
    logic                    ack;
    logic [31:0]             dat;
    logic                    irq;
    logic                    bias;
    logic [7:0]              feed;
    logic                    loop_closed;
    logic [15:0]             ref_v;
    logic                    ref_ok;
    logic [15:0]             rdbk;
  } lhrts_top_type;

  function automatic logic [15:0] lhrts_abs(input logic signed [15:0] v);
    lhrts_abs = v[15] ? 16'(-v) : 16'(v);
  endfunction
endpackage

// File: pkg/lhrts_rt_if.sv
// settings and results between the supervisor and its ring trip detector
`timescale 1ns/1ns
`default_nettype none
interface lhrts_rt_if;
  logic               ring_state;
  logic               method_ac;
  logic               two_cycles;
  logic [6:0]         ring_trip_threshold;
  logic [15:0]        ilr_lsb;
  logic signed [15:0] cur;
  logic               smp;
  logic               wrap;
  logic               trip;
  logic               blank;
  modport sup (output ring_state, method_ac, two_cycles, ring_trip_threshold, ilr_lsb, cur, smp, wrap,
               input trip, blank);
  modport det (input ring_state, method_ac, two_cycles, ring_trip_threshold, ilr_lsb, cur, smp, wrap,
               output trip, blank);
endinterface
`default_nettype wire

// File: src/lhrts_debounce.sv
// debounce timer for the raw off-hook comparator
`timescale 1ns/1ns
`default_nettype none
module lhrts_debounce #(
  parameter int CW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          smp_i,
  input  wire logic          raw_i,
  input  wire logic [CW-1:0] dur_i,
  output logic               state_o,
  output logic               rise_o,
  output logic               fall_o
);
  lhrts_pkg::lhrts_deb_type r_reg;
  lhrts_pkg::lhrts_deb_type r_next;

  always_comb begin
    r_next = r_reg;
    r_next.rise = 1'b0;
    r_next.fall = 1'b0;
    if (smp_i) begin
      if (raw_i == r_reg.state) begin
        r_next.cnt = '0;
      end else if (r_reg.cnt + 16'h0001 >= 16'(dur_i)) begin
        r_next.state = raw_i;
        r_next.rise = raw_i;
        r_next.fall = ~raw_i;
        r_next.cnt = '0;
      end else begin
        r_next.cnt = r_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign state_o = r_reg.state;
  assign rise_o = r_reg.rise;
  assign fall_o = r_reg.fall;
endmodule
`default_nettype wire

// File: src/lhrts_ringtrip.sv
// per-cycle ring trip detector with entry blanking and cycle qualification
`timescale 1ns/1ns
`default_nettype none
`include "lhrts_map.svh"
module lhrts_ringtrip (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  lhrts_rt_if.det   rt
);
  lhrts_pkg::lhrts_rt_type r_reg;
  lhrts_pkg::lhrts_rt_type r_next;
  logic [15:0] rect;
  logic [31:0] thr_sum;
  logic        ind;
  logic [1:0]  need;

  always_comb begin
    rect = (rt.method_ac == `LHRTS_METH_AC) ? (rt.cur[15] ? 16'h0000 : 16'(rt.cur))
                                            : lhrts_pkg::lhrts_abs(rt.cur);
    // average compared as sum against threshold times count: no divider needed
    thr_sum = 32'(rt.ring_trip_threshold) * 32'(r_reg.nsmp);
    ind = (r_reg.sum > thr_sum) || ({r_reg.nlim, 1'b0} > {1'b0, r_reg.nsmp});
    need = rt.two_cycles ? 2'h2 : 2'h1;
    r_next = r_reg;
    r_next.trip = 1'b0;
    r_next.prev_ring = rt.ring_state;
    if (!rt.ring_state) begin
      r_next.blank = 1'b1;
      r_next.tripped = 1'b0;
      r_next.cons = '0;
      r_next.sum = '0;
      r_next.nsmp = '0;
      r_next.nlim = '0;
    end else if (!r_reg.prev_ring) begin
      r_next.blank = 1'b1;
    end else if (rt.wrap) begin
      // a sample landing on the wrap itself is dropped
      if (!r_reg.blank && !r_reg.tripped) begin
        if (ind) begin
          r_next.cons = (r_reg.cons == 2'h3) ? r_reg.cons : r_reg.cons + 2'h1;
          if (r_reg.cons + 2'h1 >= need) begin
            r_next.trip = 1'b1;
            r_next.tripped = 1'b1;
          end
        end else begin
          r_next.cons = '0;
        end
      end
      r_next.blank = 1'b0;
      r_next.sum = '0;
      r_next.nsmp = '0;
      r_next.nlim = '0;
    end else if (rt.smp && r_reg.nsmp != 16'hFFFF) begin
      r_next.sum = r_reg.sum + 32'(rect);
      r_next.nsmp = r_reg.nsmp + 16'h0001;
      if (lhrts_pkg::lhrts_abs(rt.cur) >= rt.ilr_lsb) begin
        r_next.nlim = r_reg.nlim + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign rt.trip = r_reg.trip;
  assign rt.blank = r_reg.blank;
endmodule
`default_nettype wire

// File: src/lhrts_top.sv
// hook and ring trip supervisor for one line, with classic wishbone register slave
`timescale 1ns/1ns
`default_nettype none
`include "lhrts_map.svh"
module lhrts_top #(
  parameter int DEB_W = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`LHRTS_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   sample_valid_i,
  input  wire logic signed [15:0]     loop_current_i,
  input  wire logic signed [15:0]     line_dc_v_i,
  input  wire logic signed [15:0]     line_ac_v_i,
  input  wire logic signed [15:0]     sreg_v_i,
  input  wire logic                   ring_phase_wrap_i,
  output logic                        irq_o,
  output logic                        hook_o,
  output logic                        ring_trip_o,
  output logic                        bias_en_o,
  output logic      [7:0]             feed_res_ohms_o
);
  lhrts_pkg::lhrts_top_type r_reg;
  lhrts_pkg::lhrts_top_type r_next;

  lhrts_rt_if rt ();

  logic                    hook_state;
  logic                    hook_rise;
  logic                    hook_fall;
  logic                    raw_offhook;
  logic                    bus_req;
  logic                    bus_wr;
  logic [15:0]             mag;
  logic [15:0]             v_comp;
  logic [15:0]             v_diff;
  logic [23:0]             drop;
  logic [7:0]              feed_ohms;
  logic [`LHRTS_INT_W-1:0] ev;
  logic [`LHRTS_INT_W-1:0] clr;
  logic [31:0]             rd;

  function automatic logic [7:0] feed_sel(input logic [1:0] s);
    unique case (s)
      2'h0: feed_sel = 8'h00;
      2'h1: feed_sel = `LHRTS_FEED_R1;
      2'h2: feed_sel = `LHRTS_FEED_R2;
      2'h3: feed_sel = `LHRTS_FEED_R3;
    endcase
  endfunction

  // codes above the top of the range clamp to the maximum limit
  function automatic logic [15:0] ilr_to_lsb(input logic [5:0] code);
    logic [31:0] ma;
    ma = `LHRTS_ILR_MIN_MA + `LHRTS_ILR_STEP_MA * 32'(code);
    if (ma > `LHRTS_ILR_MAX_MA) begin
      ma = `LHRTS_ILR_MAX_MA;
    end
    ilr_to_lsb = 16'((ma * 32'd1000) / `LHRTS_CUR_LSB_UA);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    merge = m;
  endfunction

  assign rt.ring_state = r_reg.ctrl[`LHRTS_CTRL_RING];
  assign rt.method_ac = r_reg.ctrl[`LHRTS_CTRL_METH];
  assign rt.two_cycles = r_reg.ctrl[`LHRTS_CTRL_TWO];
  assign rt.ring_trip_threshold = r_reg.ring[`LHRTS_RING_RING_TRIP_THRESHOLD];
  assign rt.ilr_lsb = ilr_to_lsb(r_reg.ring[`LHRTS_RING_ILR]);
  assign rt.cur = loop_current_i;
  assign rt.smp = sample_valid_i;
  assign rt.wrap = ring_phase_wrap_i;

  lhrts_ringtrip u_rt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .rt    (rt.det)
  );

  lhrts_debounce #(
    .CW (DEB_W)
  ) u_deb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .smp_i   (sample_valid_i),
    .raw_i   (raw_offhook),
    .dur_i   (DEB_W'(r_reg.hook[`LHRTS_HOOK_DEB])),
    .state_o (hook_state),
    .rise_o  (hook_rise),
    .fall_o  (hook_fall)
  );

  always_comb begin
    feed_ohms = feed_sel(r_reg.ctrl[`LHRTS_CTRL_FEED]);
    mag = lhrts_pkg::lhrts_abs(loop_current_i);
    // feed drop removed so the idle reference is the line itself
    drop = (24'(mag) * 24'(feed_ohms)) >> `LHRTS_DROP_SHIFT;
    v_comp = 16'(line_dc_v_i) + 16'(drop[15:0]);
    v_diff = lhrts_pkg::lhrts_abs(16'(v_comp - r_reg.ref_v));
    if (r_reg.ctrl[`LHRTS_CTRL_RING]) begin
      // ringing current would fake off-hook; hold state, ring trip takes over
      raw_offhook = hook_state;
    end else if (r_reg.ctrl[`LHRTS_CTRL_LPI]) begin
      raw_offhook = r_reg.ref_ok && (v_diff > r_reg.lpi[`LHRTS_LPI_THR]);
    end else begin
      raw_offhook = mag >= r_reg.hook[`LHRTS_HOOK_THR];
    end
  end

  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i;
    // write lands on the edge that the master sees ack
    bus_wr = bus_req && wb_we_i && r_reg.ack;
    ev = '0;
    ev[`LHRTS_INT_OFF] = hook_rise;
    ev[`LHRTS_INT_ON] = hook_fall;
    ev[`LHRTS_INT_TRIP] = rt.trip;
    clr = '0;
    if (bus_wr && wb_adr_i == `LHRTS_ADR_INT && wb_sel_i[0]) begin
      clr = wb_dat_i[`LHRTS_INT_W-1:0];
    end
    unique case (wb_adr_i)
      `LHRTS_ADR_CTRL: rd = r_reg.ctrl;
      `LHRTS_ADR_HOOK: rd = r_reg.hook;
      `LHRTS_ADR_RING: rd = r_reg.ring;
      `LHRTS_ADR_STAT: rd = {28'h0000000, rt.blank, r_reg.bias, r_reg.loop_closed, hook_state};
      `LHRTS_ADR_INT:  rd = {29'h00000000, r_reg.int_st};
      `LHRTS_ADR_MASK: rd = {29'h00000000, r_reg.mask};
      `LHRTS_ADR_RDBK: rd = {16'h0000, r_reg.rdbk};
      `LHRTS_ADR_LPI:  rd = r_reg.lpi;
      default:         rd = 32'h00000000;
    endcase
  end

  always_comb begin
    r_next = r_reg;
    r_next.ack = bus_req && !r_reg.ack;
    if (bus_req && !r_reg.ack) begin
      r_next.dat = rd;
    end
    if (bus_wr) begin
      unique case (wb_adr_i)
        `LHRTS_ADR_CTRL: r_next.ctrl = merge(r_reg.ctrl, wb_dat_i, wb_sel_i) & 32'h0000_01FF;
        `LHRTS_ADR_HOOK: r_next.hook = merge(r_reg.hook, wb_dat_i, wb_sel_i);
        `LHRTS_ADR_RING: r_next.ring = merge(r_reg.ring, wb_dat_i, wb_sel_i) & 32'h0000_3F7F;
        `LHRTS_ADR_LPI:  r_next.lpi = merge(r_reg.lpi, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
        `LHRTS_ADR_MASK: r_next.mask = wb_sel_i[0] ? wb_dat_i[`LHRTS_INT_W-1:0] : r_reg.mask;
        default: ;
      endcase
    end
    r_next.int_st = (r_reg.int_st & ~clr) | ev;
    r_next.irq = |(r_next.int_st & r_next.mask);
    r_next.bias = r_next.ctrl[`LHRTS_CTRL_RING];
    r_next.feed = feed_sel(r_next.ctrl[`LHRTS_CTRL_FEED]);
    if (!r_reg.ctrl[`LHRTS_CTRL_RING]) begin
      r_next.loop_closed = 1'b0;
    end else if (rt.trip) begin
      r_next.loop_closed = 1'b1;
    end
    if (!r_reg.ctrl[`LHRTS_CTRL_LPI]) begin
      r_next.ref_ok = 1'b0;
    end else if (sample_valid_i && !r_reg.ref_ok) begin
      r_next.ref_v = v_comp;
      r_next.ref_ok = 1'b1;
    end
    if (sample_valid_i && r_reg.ctrl[`LHRTS_CTRL_TEST]) begin
      unique case (r_reg.ctrl[`LHRTS_CTRL_TSEL])
        `LHRTS_TSEL_SREG: r_next.rdbk = 16'(sreg_v_i);
        `LHRTS_TSEL_DC:   r_next.rdbk = 16'(line_dc_v_i);
        `LHRTS_TSEL_AC:   r_next.rdbk = 16'(line_ac_v_i);
        default:          r_next.rdbk = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.ctrl <= `LHRTS_CTRL_RST;
      r_reg.hook <= `LHRTS_HOOK_RST;
      r_reg.ring <= `LHRTS_RING_RST;
      r_reg.lpi <= `LHRTS_LPI_RST;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign irq_o = r_reg.irq;
  assign hook_o = hook_state;
  assign ring_trip_o = r_reg.loop_closed;
  assign bias_en_o = r_reg.bias;
  assign feed_res_ohms_o = r_reg.feed;
endmodule
`default_nettype wire

// File: verification/lhrts_host_model.sv
// host processor model: classic wishbone master
`timescale 1ns/1ns
`default_nettype none
module lhrts_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  int timeouts;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
    timeouts = 0;
  end
  // request held until ack sampled; released lines show inverted junk
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 64);
    q = dat_i;
    if (n >= 64) timeouts++;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// File: verification/lhrts_top_bench.sv
// self-checking bench for the line supervisor
`timescale 1ns/1ns
`default_nettype none
`include "lhrts_map.svh"
module lhrts_top_bench;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc, stb, we, ack, sv, wrap, irq, hook, trip, bias;
  logic [7:0]         adr, feed;
  logic [3:0]         sel;
  logic [31:0]        wdat, rdat;
  logic signed [15:0] cur = 16'sh0;
  logic signed [15:0] dcv = 16'sh0;
  int                 fails = 0;
  int                 samples_checked = 0;
  always #20 clk_i = ~clk_i;
  lhrts_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  lhrts_top #(.DEB_W(16)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sample_valid_i(sv), .loop_current_i(cur), .line_dc_v_i(dcv), .line_ac_v_i(16'sh0333),
    .sreg_v_i(16'sh0111), .ring_phase_wrap_i(wrap), .irq_o(irq), .hook_o(hook), .ring_trip_o(trip),
    .bias_en_o(bias), .feed_res_ohms_o(feed));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    host.access(1'b0, a, 32'h0, q);
    cmp(n, e, q);
  endtask
  task automatic smp(input logic signed [15:0] c, input logic signed [15:0] d);
    @(posedge clk_i);
    sv <= 1'b1;
    cur <= c;
    dcv <= d;
    @(posedge clk_i);
    sv <= 1'b0;
  endtask
  // wrap on its own cycle; a coinciding sample would be dropped
  task automatic ringcyc(input logic signed [15:0] a, input logic signed [15:0] b);
    repeat (4) begin
      smp(a, 16'sh0);
      smp(b, 16'sh0);
    end
    @(posedge clk_i);
    wrap <= 1'b1;
    @(posedge clk_i);
    wrap <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic summarize;
    fails += host.timeouts;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  logic [7:0]  feed_tab [4] = '{8'h00, `LHRTS_FEED_R1, `LHRTS_FEED_R2, `LHRTS_FEED_R3};
  logic [31:0] rdbk_tab [4] = '{32'h0000_0111, 32'h0000_0222, 32'h0000_0333, 32'h0};
  initial begin
    sv = 1'b0;
    wrap = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`LHRTS_ADR_CTRL, `LHRTS_CTRL_RST, "ctrl");
    rd(`LHRTS_ADR_HOOK, `LHRTS_HOOK_RST, "hook reg");
    rd(`LHRTS_ADR_RING, `LHRTS_RING_RST, "ring reg");
    rd(`LHRTS_ADR_LPI, `LHRTS_LPI_RST, "lpi reg");
    rd(`LHRTS_ADR_MASK, 32'h0, "mask");
    rd(8'h20, 32'h0, "unmapped");
    wr(`LHRTS_ADR_STAT, 32'hFFFF_FFFF);
    rd(`LHRTS_ADR_STAT, 32'h8, "stat ro");
    $display("test registers done");
    wr(`LHRTS_ADR_MASK, 32'h7);
    wr(`LHRTS_ADR_HOOK, 32'h0003_0014);
    smp(16'sh19, 16'sh0);
    smp(-16'sh19, 16'sh0);
    smp(16'sh5, 16'sh0);
    smp(16'sh14, 16'sh0);
    smp(16'sh19, 16'sh0);
    settle();
    cmp("hook early", 32'h0, {31'h0, hook});
    smp(-16'sh14, 16'sh0);
    settle();
    cmp("hook", 32'h1, {31'h0, hook});
    cmp("irq", 32'h1, {31'h0, irq});
    rd(`LHRTS_ADR_INT, 32'h1, "int off");
    wr(`LHRTS_ADR_INT, 32'h1);
    settle();
    cmp("irq clr", 32'h0, {31'h0, irq});
    repeat (3) smp(16'sh0, 16'sh0);
    settle();
    cmp("hook on", 32'h0, {31'h0, hook});
    rd(`LHRTS_ADR_INT, 32'h4, "int on");
    wr(`LHRTS_ADR_INT, 32'h4);
    $display("test hook done");
    for (int i = 0; i < 4; i++) begin
      wr(`LHRTS_ADR_CTRL, 32'h8 | (i << 4));
      settle();
      cmp("feed", {24'h0, feed_tab[i]}, {24'h0, feed});
      wr(`LHRTS_ADR_CTRL, 32'h108 | (i << 6));
      smp(16'sh0, 16'sh0222);
      rd(`LHRTS_ADR_RDBK, rdbk_tab[i], "readback");
    end
    $display("test feed readback done");
    wr(`LHRTS_ADR_RING, 32'h0000_0614);
    wr(`LHRTS_ADR_CTRL, 32'hD);
    settle();
    cmp("bias", 32'h1, {31'h0, bias});
    rd(`LHRTS_ADR_STAT, 32'hC, "blank");
    ringcyc(16'sh50, 16'sh50);
    cmp("trip blank", 32'h0, {31'h0, trip});
    ringcyc(16'sh1E, -16'sh1E);
    ringcyc(16'sh1E, -16'sh1E);
    cmp("trip half", 32'h0, {31'h0, trip});
    wr(`LHRTS_ADR_CTRL, 32'h9);
    ringcyc(16'sh1E, -16'sh1E);
    cmp("trip one", 32'h0, {31'h0, trip});
    ringcyc(16'sh1E, -16'sh1E);
    cmp("trip full", 32'h1, {31'h0, trip});
    rd(`LHRTS_ADR_INT, 32'h2, "int trip");
    rd(`LHRTS_ADR_STAT, 32'h6, "stat loop");
    wr(`LHRTS_ADR_CTRL, 32'h8);
    wr(`LHRTS_ADR_INT, 32'h2);
    settle();
    cmp("trip off", 32'h0, {31'h0, trip});
    cmp("bias off", 32'h0, {31'h0, bias});
    wr(`LHRTS_ADR_RING, 32'h0000_067F);
    wr(`LHRTS_ADR_CTRL, 32'h5);
    ringcyc(16'sh0, 16'sh0);
    ringcyc(-16'sh46, 16'sh0);
    cmp("limit half", 32'h0, {31'h0, trip});
    ringcyc(-16'sh46, -16'sh46);
    cmp("limit trip", 32'h1, {31'h0, trip});
    wr(`LHRTS_ADR_CTRL, 32'h8);
    wr(`LHRTS_ADR_INT, 32'h2);
    $display("test ring trip done");
    wr(`LHRTS_ADR_CTRL, 32'hA);
    smp(16'sh0, 16'sh64);
    repeat (3) smp(16'sh0, 16'sh69);
    settle();
    cmp("lpi small", 32'h0, {31'h0, hook});
    repeat (3) smp(16'sh0, 16'sh6E);
    settle();
    cmp("lpi hook", 32'h1, {31'h0, hook});
    $display("test low power idle done");
    summarize();
  end
endmodule
`default_nettype wire

// File: verification/lhrts_top_sva.sv
// assertion checker on the supervisor top ports
`timescale 1ns/1ns
`default_nettype none
`include "lhrts_map.svh"
module lhrts_top_sva #(
  parameter int DEB_W = 16
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`LHRTS_AW-1:0] wb_adr_i,
  input  wire logic [31:0]          wb_dat_o,
  input  wire logic                 wb_ack_o,
  input  wire logic                 sample_valid_i,
  input  wire logic                 ring_phase_wrap_i,
  input  wire logic                 irq_o,
  input  wire logic                 hook_o,
  input  wire logic                 ring_trip_o,
  input  wire logic                 bias_en_o,
  input  wire logic [7:0]           feed_res_ohms_o
);
  logic       ctrl_wr;
  logic [2:0] wr_hist;
  assign ctrl_wr = wb_ack_o && wb_we_i && (wb_adr_i == `LHRTS_ADR_CTRL);
  // recent completed writes; w1c clear and mask both lower irq
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_hist <= 3'h0;
    end else begin
      wr_hist <= {wr_hist[1:0], wb_ack_o && wb_we_i};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i > `LHRTS_ADR_LPI |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_bias; $changed(bias_en_o) |-> $past(ctrl_wr, 1); endproperty
  a_bias: assert property (p_bias) else $error("bias moved without ctrl write");
  property p_trip_bias; $rose(ring_trip_o) |-> bias_en_o; endproperty
  a_trip_bias: assert property (p_trip_bias) else $error("trip outside ringing");
  property p_trip_wrap;
    $rose(ring_trip_o) |-> $past(ring_phase_wrap_i, 1) || $past(ring_phase_wrap_i, 2) || $past(ring_phase_wrap_i, 3);
  endproperty
  a_trip_wrap: assert property (p_trip_wrap) else $error("trip not at cycle end");
  property p_hook_smp; $changed(hook_o) |-> $past(sample_valid_i, 1) || $past(sample_valid_i, 2); endproperty
  a_hook_smp: assert property (p_hook_smp) else $error("hook moved without sample");
  property p_irq_fall; $fell(irq_o) |-> wr_hist != 3'h0; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  property p_feed_val;
    feed_res_ohms_o inside {8'h00, `LHRTS_FEED_R1, `LHRTS_FEED_R2, `LHRTS_FEED_R3};
  endproperty
  a_feed_val: assert property (p_feed_val) else $error("feed value illegal");
  property p_feed_chg; $changed(feed_res_ohms_o) |-> $past(ctrl_wr, 1); endproperty
  a_feed_chg: assert property (p_feed_chg) else $error("feed moved without write");
endmodule
bind lhrts_top lhrts_top_sva #(.DEB_W(DEB_W)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_valid_i(sample_valid_i), .ring_phase_wrap_i(ring_phase_wrap_i), .irq_o(irq_o), .hook_o(hook_o),
  .ring_trip_o(ring_trip_o), .bias_en_o(bias_en_o), .feed_res_ohms_o(feed_res_ohms_o));
`default_nettype wire
